// File: csdm_pkg.sv
// constants, state layout and operation codes for the status and data memory map block
package csdm_pkg;

  // register offsets in the special register space
  localparam logic [7:0]  ADDR_STATUS     = 8'hD0;
  localparam logic [7:0]  ADDR_SECOND     = 8'hF0;
  localparam logic [7:0]  ADDR_STACK_TOP  = 8'h81;
  localparam logic [7:0]  ADDR_PAGE       = 8'hAA;

  // reset values
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  SECOND_RESET    = 8'h00;
  localparam logic [7:0]  STACK_RESET     = 8'h07;
  localparam logic        PAGE_RESET      = 1'b0;

  // status field positions
  localparam int          CARRY_BIT       = 7;
  localparam int          HALF_BIT        = 6;
  localparam int          USER0_BIT       = 5;
  localparam int          BANK_HI         = 4;
  localparam int          BANK_LO         = 3;
  localparam int          WRAP_BIT        = 2;
  localparam int          USER1_BIT       = 1;
  localparam int          PARITY_BIT      = 0;

  // memory map figures
  localparam logic [7:0]  DIRECT_TOP      = 8'h7F;
  localparam logic [7:0]  BIT_BASE        = 8'h20;
  localparam logic [15:0] FLASH_TOP       = 16'h3DFF;
  localparam int          ONCHIP_EXT_RAM_BYTES      = 512;
  localparam int          ONCHIP_EXT_RAM_AW         = 9;

  // internal memory operations from the execution unit
  typedef enum logic [2:0] {
    OP_NONE,
    OP_DIRECT,
    OP_INDIRECT,
    OP_REG,
    OP_BIT,
    OP_PUSH,
    OP_POP
  } csdm_op_e;

  // arithmetic kinds that touch the status flags
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_ADDC,
    ALU_SUBB,
    ALU_MUL,
    ALU_DIV,
    ALU_OTHER
  } csdm_alu_e;

  // state of the main module
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] second;
    logic [7:0] stack_top;
    logic       page;
    logic [7:0] rdata;
    logic       rvalid;
  } csdm_state_s;

endpackage

// File: csdm_flags.sv
// arithmetic flag update for carry, half carry and signed wrap
module csdm_flags (
  // arithmetic result
  input  wire csdm_pkg::csdm_alu_e alu_kind_i,
  input  wire logic                carry_i,
  input  wire logic                half_i,
  input  wire logic                wrap_i,
  // current flags
  input  wire logic [7:0]          status_i,
  // next flags
  output logic                     carry_o,
  output logic                     half_o,
  output logic                     wrap_o
);

  // add and subtract take the result flags, multiply, divide and other clear carry and half carry
  always_comb begin
    carry_o = status_i[csdm_pkg::CARRY_BIT];
    half_o  = status_i[csdm_pkg::HALF_BIT];
    wrap_o  = status_i[csdm_pkg::WRAP_BIT];
    case (alu_kind_i)
      csdm_pkg::ALU_ADD, csdm_pkg::ALU_ADDC, csdm_pkg::ALU_SUBB: begin
        carry_o = carry_i;
        half_o  = half_i;
        wrap_o  = wrap_i;
      end
      csdm_pkg::ALU_MUL, csdm_pkg::ALU_DIV: begin
        carry_o = 1'b0;
        half_o  = 1'b0;
        wrap_o  = wrap_i;
      end
      csdm_pkg::ALU_OTHER: begin
        carry_o = 1'b0;
        half_o  = 1'b0;
      end
      default: ;
    endcase
  end

endmodule

// File: csdm_onchip_ext_ram.sv
// on-chip external RAM with one registered read port
module csdm_onchip_ext_ram #(
  parameter int DEPTH = csdm_pkg::ONCHIP_EXT_RAM_BYTES,
  parameter int AW    = csdm_pkg::ONCHIP_EXT_RAM_AW
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // access port
  input  wire logic          req_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  // read answer
  output logic [7:0]         rdata_o,
  output logic               valid_o
);

  typedef struct packed {
    logic [7:0] rdata;
    logic       valid;
  } csdm_onchip_ext_ram_s;

  csdm_onchip_ext_ram_s st;
  csdm_onchip_ext_ram_s next_st;
  logic [7:0] mem [0:DEPTH-1];

  // read data is captured one cycle after a read request
  always_comb begin
    next_st       = st;
    next_st.valid = req_i && !we_i;
    if (req_i && !we_i) begin
      next_st.rdata = mem[addr_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // array write
  always_ff @(posedge clk_i) begin
    if (req_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = st.rdata;
  assign valid_o = st.valid;

  a_onchip_ext_ram_read_valid: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i && !we_i |=> valid_o) else $error("external RAM read gave no answer");

endmodule

// File: csdm_core.sv
// status flags, internal RAM decode, stack and external memory routing
module csdm_core (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // internal memory request
  input  wire csdm_pkg::csdm_op_e  op_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  output logic [7:0]               rdata_o,
  output logic                     rvalid_o,
  // arithmetic flag update
  input  wire csdm_pkg::csdm_alu_e alu_kind_i,
  input  wire logic                carry_i,
  input  wire logic                half_i,
  input  wire logic                wrap_i,
  input  wire logic [7:0]          primary_operand_i,
  // second operand load from multiply and divide
  input  wire logic                second_load_i,
  input  wire logic [7:0]          second_data_i,
  // forwarded special register access
  output logic                     sfr_req_o,
  output logic                     sfr_we_o,
  output logic [7:0]               sfr_addr_o,
  output logic [7:0]               sfr_wdata_o,
  input  wire logic [7:0]          sfr_rdata_i,
  // external move
  input  wire logic                xmov_req_i,
  input  wire logic                xmov_we_i,
  input  wire logic                xmov_wide_i,
  input  wire logic [15:0]         xmov_ptr_i,
  input  wire logic [7:0]          xmov_wdata_i,
  input  wire logic                flash_cfg_i,
  output logic [7:0]               xmov_rdata_o,
  output logic                     xmov_valid_o,
  // flash decode
  input  wire logic                code_req_i,
  input  wire logic [15:0]         code_addr_i,
  output logic                     flash_rd_o,
  output logic                     code_lock_o,
  output logic                     code_reserved_o,
  output logic                     flash_wr_o,
  output logic [15:0]              flash_wr_addr_o,
  output logic [7:0]               flash_wdata_o,
  // register views
  output logic [7:0]               program_status_flags_o,
  output logic [7:0]               second_operand_o,
  output logic [7:0]               stack_top_pointer_o,
  output logic [7:0]               onchip_ext_ram_page_reg_o
);

  csdm_pkg::csdm_state_s st;
  csdm_pkg::csdm_state_s next_st;

  logic [7:0]  iram [0:255];
  logic [1:0]  bank;
  logic [7:0]  status_live;
  logic [7:0]  ptr_addr;
  logic [7:0]  iram_addr;
  logic [7:0]  iram_rd;
  logic [7:0]  byte_addr;
  logic [7:0]  own_val;
  logic [7:0]  byte_val;
  logic [7:0]  wbyte;
  logic        own_hit;
  logic        sfr_space;
  logic        iram_we;
  logic        rd_op;
  logic        own_we;
  logic        carry_next;
  logic        half_next;
  logic        wrap_next;
  logic [csdm_pkg::ONCHIP_EXT_RAM_AW-1:0] onchip_ext_ram_addr;
  logic        onchip_ext_ram_req;

  // active bank and live parity
  assign bank        = st.status[csdm_pkg::BANK_HI:csdm_pkg::BANK_LO];
  assign status_live = {st.status[7:1], ^primary_operand_i};

  csdm_flags u_flags (
    .alu_kind_i (alu_kind_i),
    .carry_i    (carry_i),
    .half_i     (half_i),
    .wrap_i     (wrap_i),
    .status_i   (st.status),
    .carry_o    (carry_next),
    .half_o     (half_next),
    .wrap_o     (wrap_next)
  );

  // address decode of the internal memory request
  always_comb begin
    ptr_addr  = {3'b000, bank, 2'b00, addr_i[0]};
    iram_addr = 8'h00;
    byte_addr = addr_i;
    sfr_space = 1'b0;
    case (op_i)
      csdm_pkg::OP_REG: begin
        iram_addr = {3'b000, bank, addr_i[2:0]};
      end
      csdm_pkg::OP_INDIRECT: begin
        iram_addr = iram[ptr_addr];
      end
      csdm_pkg::OP_DIRECT: begin
        iram_addr = addr_i;
        sfr_space = addr_i > csdm_pkg::DIRECT_TOP;
      end
      csdm_pkg::OP_BIT: begin
        if (addr_i > csdm_pkg::DIRECT_TOP) begin
          byte_addr = {addr_i[7:3], 3'b000};
          sfr_space = 1'b1;
        end else begin
          iram_addr = csdm_pkg::BIT_BASE + {4'h0, addr_i[6:3]};
        end
      end
      csdm_pkg::OP_PUSH: begin
        iram_addr = st.stack_top + 8'h01;
      end
      csdm_pkg::OP_POP: begin
        iram_addr = st.stack_top;
      end
      default: ;
    endcase
    iram_rd = iram[iram_addr];
  end

  // registers held inside this block
  always_comb begin
    own_hit = 1'b1;
    own_val = 8'h00;
    case (byte_addr)
      csdm_pkg::ADDR_STATUS:    own_val = status_live;
      csdm_pkg::ADDR_SECOND:    own_val = st.second;
      csdm_pkg::ADDR_STACK_TOP: own_val = st.stack_top;
      csdm_pkg::ADDR_PAGE:      own_val = {7'h00, st.page};
      default:                  own_hit = 1'b0;
    endcase
  end

  // byte read, bit merge and write routing
  always_comb begin
    byte_val = sfr_space ? (own_hit ? own_val : sfr_rdata_i) : iram_rd;
    wbyte    = wdata_i;
    if (op_i == csdm_pkg::OP_BIT) begin
      wbyte             = byte_val;
      wbyte[addr_i[2:0]] = wdata_i[0];
    end
  end

  assign sfr_req_o   = sfr_space && !own_hit;
  assign sfr_we_o    = sfr_space && !own_hit && we_i;
  assign sfr_addr_o  = byte_addr;
  assign sfr_wdata_o = wbyte;
  assign own_we      = sfr_space && own_hit && we_i;
  assign rd_op       = (op_i == csdm_pkg::OP_POP) ||
                       (op_i != csdm_pkg::OP_NONE && op_i != csdm_pkg::OP_PUSH && !we_i);
  assign iram_we     = !sfr_space && (op_i == csdm_pkg::OP_PUSH ||
                       (we_i && op_i != csdm_pkg::OP_NONE && op_i != csdm_pkg::OP_POP));

  // next state of the held registers
  always_comb begin
    next_st        = st;
    next_st.rvalid = rd_op;
    if (rd_op) begin
      next_st.rdata = (op_i == csdm_pkg::OP_BIT) ? {7'h00, byte_val[addr_i[2:0]]} : byte_val;
    end
    if (own_we) begin
      case (byte_addr)
        csdm_pkg::ADDR_STATUS:    next_st.status = {wbyte[7:1], 1'b0};
        csdm_pkg::ADDR_SECOND:    next_st.second = wbyte;
        csdm_pkg::ADDR_STACK_TOP: next_st.stack_top = wbyte;
        csdm_pkg::ADDR_PAGE:      next_st.page = wbyte[0];
        default: ;
      endcase
    end
    if (op_i == csdm_pkg::OP_PUSH) begin
      next_st.stack_top = st.stack_top + 8'h01;
    end else if (op_i == csdm_pkg::OP_POP) begin
      next_st.stack_top = st.stack_top - 8'h01;
    end
    // arithmetic results win over a software write in the same cycle; user flags untouched
    if (alu_kind_i != csdm_pkg::ALU_NONE) begin
      next_st.status[csdm_pkg::CARRY_BIT] = carry_next;
      next_st.status[csdm_pkg::HALF_BIT]  = half_next;
      next_st.status[csdm_pkg::WRAP_BIT]  = wrap_next;
    end
    if (second_load_i) begin
      next_st.second = second_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.status    <= csdm_pkg::STATUS_RESET;
      st.second    <= csdm_pkg::SECOND_RESET;
      st.stack_top <= csdm_pkg::STACK_RESET;
      st.page      <= csdm_pkg::PAGE_RESET;
      st.rdata     <= 8'h00;
      st.rvalid    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // internal RAM write, full 256 bytes
  always_ff @(posedge clk_i) begin
    if (iram_we) begin
      iram[iram_addr] <= wbyte;
    end
  end

  // external move routing between RAM and flash
  assign onchip_ext_ram_addr = xmov_wide_i ? xmov_ptr_i[csdm_pkg::ONCHIP_EXT_RAM_AW-1:0]
                                 : {st.page, xmov_ptr_i[7:0]};
  assign onchip_ext_ram_req  = xmov_req_i && !(xmov_we_i && flash_cfg_i);
  assign flash_wr_o      = xmov_req_i && xmov_we_i && flash_cfg_i;
  assign flash_wr_addr_o = xmov_wide_i ? xmov_ptr_i : {7'h00, st.page, xmov_ptr_i[7:0]};
  assign flash_wdata_o   = xmov_wdata_i;

  csdm_onchip_ext_ram #(
    .DEPTH (csdm_pkg::ONCHIP_EXT_RAM_BYTES),
    .AW    (csdm_pkg::ONCHIP_EXT_RAM_AW)
  ) u_onchip_ext_ram (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .req_i   (onchip_ext_ram_req),
    .we_i    (xmov_we_i),
    .addr_i  (onchip_ext_ram_addr),
    .wdata_i (xmov_wdata_i),
    .rdata_o (xmov_rdata_o),
    .valid_o (xmov_valid_o)
  );

  // code space decode
  assign flash_rd_o      = code_req_i && (code_addr_i <= csdm_pkg::FLASH_TOP);
  assign code_lock_o     = code_req_i && (code_addr_i == csdm_pkg::FLASH_TOP);
  assign code_reserved_o = code_req_i && (code_addr_i > csdm_pkg::FLASH_TOP);

  // register views
  assign rdata_o                = st.rdata;
  assign rvalid_o               = st.rvalid;
  assign program_status_flags_o = status_live;
  assign second_operand_o       = st.second;
  assign stack_top_pointer_o    = st.stack_top;
  assign onchip_ext_ram_page_reg_o        = {7'h00, st.page};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_stack_push_step: assert property (op_i == csdm_pkg::OP_PUSH |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01) else $error("push step wrong");
  a_stack_reset_value: assert property ($past(reset_i) |->
    stack_top_pointer_o == 8'h07) else $error("stack pointer not 0x07 after reset");
  a_push_pop_data: assert property (op_i == csdm_pkg::OP_PUSH ##1 op_i == csdm_pkg::OP_POP
    |=> rdata_o == $past(wdata_i, 2)) else $error("popped byte differs from pushed");
  a_carry_follows: assert property (alu_kind_i == csdm_pkg::ALU_ADD |=>
    program_status_flags_o[7] == $past(carry_i)) else $error("carry flag wrong");
  a_wrap_clear_mul: assert property ((alu_kind_i == csdm_pkg::ALU_MUL) && !wrap_i |=>
    !program_status_flags_o[2] && !program_status_flags_o[7]) else $error("wrap not cleared");
  a_user_flags_keep: assert property (alu_kind_i != csdm_pkg::ALU_NONE && !own_we |=>
    $stable(program_status_flags_o[5]) && $stable(program_status_flags_o[1]))
    else $error("user flag changed by hardware");
  a_direct_high_route: assert property (op_i == csdm_pkg::OP_DIRECT && addr_i == 8'hE0
    |-> sfr_req_o) else $error("direct high access not forwarded");
  a_page_read_zero: assert property (op_i == csdm_pkg::OP_DIRECT && !we_i &&
    addr_i == 8'hAA |=> rvalid_o && rdata_o[7:1] == 7'h00) else $error("page upper bits set");
  a_parity_tracks: assert property (##1 program_status_flags_o[0] ==
    ^primary_operand_i) else $error("parity does not follow accumulator");
  a_flash_write_route: assert property (xmov_req_i && xmov_we_i && !flash_cfg_i |->
    !flash_wr_o ##1 !xmov_valid_o) else $error("external write leaked to flash");

  // decode checks: lock byte, bit region, divide by zero, forwarding and paging
  a_lock_byte_decode: assert property (code_req_i &&
    code_addr_i == csdm_pkg::FLASH_TOP |-> flash_rd_o && code_lock_o && !code_reserved_o)
    else $error("lock byte decode wrong");
  a_bit_region_write: assert property (op_i == csdm_pkg::OP_BIT && we_i &&
    addr_i <= csdm_pkg::DIRECT_TOP |-> iram_we && iram_addr[7:4] == 4'h2)
    else $error("bit write missed the bit region");
  a_div_zero_wrap: assert property (alu_kind_i == csdm_pkg::ALU_DIV && wrap_i |=>
    program_status_flags_o[2]) else $error("divide by zero left wrap clear");
  a_direct_forward: assert property (op_i == csdm_pkg::OP_DIRECT &&
    addr_i > csdm_pkg::DIRECT_TOP && !own_hit |-> sfr_req_o && sfr_addr_o == addr_i)
    else $error("direct access above the low half not forwarded");
  a_page_bit_route: assert property (xmov_req_i && !xmov_wide_i |->
    onchip_ext_ram_addr[csdm_pkg::ONCHIP_EXT_RAM_AW-1] == st.page)
    else $error("page bit not used as high address");

  c_push_pop: cover property (op_i == csdm_pkg::OP_PUSH ##1 op_i == csdm_pkg::OP_POP);
  c_bit_write: cover property (op_i == csdm_pkg::OP_BIT && we_i && addr_i < 8'h80);
  c_indirect_high: cover property (op_i == csdm_pkg::OP_INDIRECT && iram_addr > 8'h7F);
  c_onchip_ext_ram_page_read: cover property (xmov_req_i && !xmov_wide_i && st.page ##1 xmov_valid_o);
  // a wide pointer with upper bits set lands on an alias of the RAM
  c_wide_alias: cover property (xmov_req_i && xmov_wide_i && xmov_ptr_i[15:9] != 7'h00);

endmodule

// File: csdm_sfr_model.sv
// special register responder for the addresses that the block forwards
module csdm_sfr_model (
  // clock
  input  wire logic       clk_i,
  // forwarded access
  input  wire logic       sfr_req_i,
  input  wire logic       sfr_we_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic [7:0]      sfr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [256];
  logic [7:0] last;
  // same-cycle answer; outside a request the bus shows a changing pattern
  always_comb begin
    sfr_rdata_o = sfr_req_i ? regs[sfr_addr_i] : ~last;
  end
  // preset contents, then store writes and remember the bus level
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
    last = 8'h00;
  end
  always @(posedge clk_i) begin
    if (sfr_req_i && sfr_we_i) regs[sfr_addr_i] <= sfr_wdata_i;
    last <= sfr_rdata_o;
  end
endmodule

// File: testbench.sv
// self-checking bench for the status and data memory map block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, reset_i, we_i, carry_i, half_i, wrap_i, second_load_i, rvalid_o;
  logic sfr_req_o, sfr_we_o, xmov_req_i, xmov_we_i, xmov_wide_i, flash_cfg_i;
  logic xmov_valid_o, code_req_i, flash_rd_o, code_lock_o, code_reserved_o, flash_wr_o;
  logic [7:0] addr_i, wdata_i, rdata_o, primary_operand_i, second_data_i, sfr_addr_o;
  logic [7:0] sfr_wdata_o, sfr_rdata_i, xmov_wdata_i, xmov_rdata_o, flash_wdata_o;
  logic [7:0] program_status_flags_o, second_operand_o, stack_top_pointer_o, onchip_ext_ram_page_reg_o;
  logic [15:0] xmov_ptr_i, code_addr_i, flash_wr_addr_o;
  csdm_pkg::csdm_op_e  op_i;
  csdm_pkg::csdm_alu_e alu_kind_i;
  // reference state
  logic [7:0] ram [256];
  logic [7:0] xr [512];
  logic [7:0] sfrm [256];
  logic [7:0] st, sp, sec, rq, v, d, a, n;
  logic       pg;
  int         err_count, checks, cyc;

  csdm_core csdm_core_inst (.clk_i(clk_i), .reset_i(reset_i), .op_i(op_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .alu_kind_i(alu_kind_i), .carry_i(carry_i), .half_i(half_i), .wrap_i(wrap_i),
    .primary_operand_i(primary_operand_i), .second_load_i(second_load_i),
    .second_data_i(second_data_i), .sfr_req_o(sfr_req_o), .sfr_we_o(sfr_we_o),
    .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o), .sfr_rdata_i(sfr_rdata_i),
    .xmov_req_i(xmov_req_i), .xmov_we_i(xmov_we_i), .xmov_wide_i(xmov_wide_i),
    .xmov_ptr_i(xmov_ptr_i), .xmov_wdata_i(xmov_wdata_i), .flash_cfg_i(flash_cfg_i),
    .xmov_rdata_o(xmov_rdata_o), .xmov_valid_o(xmov_valid_o), .code_req_i(code_req_i),
    .code_addr_i(code_addr_i), .flash_rd_o(flash_rd_o), .code_lock_o(code_lock_o),
    .code_reserved_o(code_reserved_o), .flash_wr_o(flash_wr_o),
    .flash_wr_addr_o(flash_wr_addr_o), .flash_wdata_o(flash_wdata_o),
    .program_status_flags_o(program_status_flags_o), .second_operand_o(second_operand_o),
    .stack_top_pointer_o(stack_top_pointer_o), .onchip_ext_ram_page_reg_o(onchip_ext_ram_page_reg_o));
  csdm_sfr_model csdm_sfr_model_inst (.clk_i(clk_i), .sfr_req_i(sfr_req_o),
    .sfr_we_i(sfr_we_o), .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o),
    .sfr_rdata_o(sfr_rdata_i));

  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one internal memory operation, held for one cycle; read data lands in rq
  task automatic mem(input csdm_pkg::csdm_op_e o, input logic w, input logic [7:0] ad,
                     input logic [7:0] wd);
    op_i = o;
    we_i = w;
    addr_i = ad;
    wdata_i = wd;
    @(negedge clk_i);
    rq = rdata_o;
    if (o != csdm_pkg::OP_PUSH && (!w || o == csdm_pkg::OP_POP)) chk(rvalid_o, 1'b1);
  endtask
  // one external move with its reference update and checks
  task automatic xm(input logic w, input logic wide, input logic [15:0] p,
                    input logic [7:0] wd);
    logic [8:0] ix;
    ix = wide ? p[8:0] : {pg, p[7:0]};
    xmov_req_i = 1'b1;
    xmov_we_i = w;
    xmov_wide_i = wide;
    xmov_ptr_i = p;
    xmov_wdata_i = wd;
    #1;
    if (w) chk(flash_wr_o, flash_cfg_i);
    if (w && flash_cfg_i) chk(flash_wr_addr_o, wide ? p : {7'h00, pg, p[7:0]});
    if (w && flash_cfg_i) chk(flash_wdata_o, wd);
    @(negedge clk_i);
    if (w && !flash_cfg_i) xr[ix] = wd;
    if (!w) chk(xmov_valid_o, 1'b1);
    if (!w) chk(xmov_rdata_o, xr[ix]);
  endtask
  function automatic logic [7:0] stx();
    return {st[7:1], ^primary_operand_i};
  endfunction

  // main sequence
  initial begin
    {reset_i, we_i, carry_i, half_i, wrap_i, second_load_i} = 6'h20;
    {xmov_req_i, xmov_we_i, xmov_wide_i, flash_cfg_i, code_req_i} = 5'h00;
    {addr_i, wdata_i, second_data_i, xmov_wdata_i} = 32'h0;
    {xmov_ptr_i, code_addr_i} = 32'h0;
    op_i = csdm_pkg::OP_NONE;
    alu_kind_i = csdm_pkg::ALU_NONE;
    for (int i = 0; i < 256; i++) sfrm[i] = 8'(i) ^ 8'h5A;
    void'($urandom(32'h46EB));
    primary_operand_i = $urandom;
    {st, sp, sec, pg} = {8'h00, 8'h07, 8'h00, 1'b0};
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk(second_operand_o, 8'h00);
    chk(stack_top_pointer_o, 8'h07);
    chk(onchip_ext_ram_page_reg_o, 8'h00);
    chk(program_status_flags_o, stx());
    // own registers: write, read back, read-only and unused bits
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hF0, v);
      mem(csdm_pkg::OP_DIRECT, 1'b0, 8'hF0, 8'h00);
      chk(rq, v);
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hAA, v);
      pg = v[0];
      mem(csdm_pkg::OP_DIRECT, 1'b0, 8'hAA, 8'h00);
      chk(rq, {7'h00, pg});
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hD0, v);
      st = v & 8'hFE;
      mem(csdm_pkg::OP_DIRECT, 1'b0, 8'hD0, 8'h00);
      chk(rq, stx());
    end
    // stack from reset value, back-to-back pushes and pops
    for (int k = 0; k < 3; k++) begin
      d = $urandom;
      mem(csdm_pkg::OP_PUSH, 1'b0, 8'h00, d);
      sp++;
      ram[sp] = d;
    end
    chk(stack_top_pointer_o, 8'h0A);
    mem(csdm_pkg::OP_DIRECT, 1'b0, 8'h08, 8'h00);
    chk(rq, ram[8]);
    for (int k = 0; k < 3; k++) begin
      mem(csdm_pkg::OP_POP, 1'b1, 8'h00, 8'h00);
      chk(rq, ram[sp]);
      sp--;
    end
    mem(csdm_pkg::OP_DIRECT, 1'b1, 8'h81, 8'hFE);
    sp = 8'hFE;
    mem(csdm_pkg::OP_PUSH, 1'b0, 8'h00, 8'h3C);
    mem(csdm_pkg::OP_PUSH, 1'b0, 8'h00, 8'hC3);
    mem(csdm_pkg::OP_POP, 1'b0, 8'h00, 8'h00);
    chk(rq, 8'hC3);
    chk(stack_top_pointer_o, 8'hFF);
    mem(csdm_pkg::OP_PUSH, 1'b0, 8'h00, 8'hC3);
    mem(csdm_pkg::OP_DIRECT, 1'b0, 8'h00, 8'h00);
    chk(rq, 8'hC3);
    chk(stack_top_pointer_o, 8'h00);
    // each bank maps register index to its own eight bytes
    for (int b = 0; b < 4; b++) begin
      st = 8'(b << 3);
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hD0, st);
      n = $urandom % 8;
      d = $urandom;
      mem(csdm_pkg::OP_REG, 1'b1, n, d);
      ram[b * 8 + n] = d;
      mem(csdm_pkg::OP_DIRECT, 1'b0, 8'(b * 8) + n, 8'h00);
      chk(rq, d);
    end
    // indirect through R0 or R1 of bank 3 over the whole RAM
    for (int k = 0; k < 10; k++) begin
      a = $urandom;
      d = $urandom;
      mem(csdm_pkg::OP_REG, 1'b1, 8'(k % 2), a);
      ram[24 + k % 2] = a;
      mem(csdm_pkg::OP_INDIRECT, 1'b1, 8'(k % 2), d);
      ram[ram[24 + k % 2]] = d;
      mem(csdm_pkg::OP_INDIRECT, 1'b0, 8'(k % 2), 8'h00);
      chk(rq, ram[ram[24 + k % 2]]);
      a = 8'h90 | 8'($urandom % 16);
      mem(csdm_pkg::OP_DIRECT, 1'b0, a, 8'h00);
      chk(rq, sfrm[a]);
    end
    // bit access versus byte access over the bit region
    for (int k = 0; k < 16; k++) begin
      ram[32 + k] = $urandom;
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'h20 + 8'(k), ram[32 + k]);
    end
    for (int k = 0; k < 8; k++) begin
      n = $urandom % 128;
      v = $urandom % 2;
      mem(csdm_pkg::OP_BIT, 1'b1, n, v);
      ram[32 + n[6:3]][n[2:0]] = v[0];
      mem(csdm_pkg::OP_BIT, 1'b0, n, 8'h00);
      chk(rq, v);
      mem(csdm_pkg::OP_DIRECT, 1'b0, 8'h20 + 8'(n[6:3]), 8'h00);
      chk(rq, ram[32 + n[6:3]]);
    end
    // arithmetic flag updates with user flags and live parity
    st = 8'h22;
    mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hD0, st);
    op_i = csdm_pkg::OP_NONE;
    for (int k = 0; k < 18; k++) begin
      alu_kind_i = csdm_pkg::csdm_alu_e'(1 + k % 6);
      {carry_i, half_i, wrap_i} = 3'($urandom);
      primary_operand_i = $urandom;
      #1;
      chk(program_status_flags_o[0], ^primary_operand_i);
      if (k % 6 < 3) {st[7], st[6]} = {carry_i, half_i};
      else {st[7], st[6]} = 2'b00;
      if (k % 6 < 5) st[2] = wrap_i;
      @(negedge clk_i);
      chk(program_status_flags_o, stx());
    end
    alu_kind_i = csdm_pkg::ALU_NONE;
    second_load_i = 1'b1;
    second_data_i = $urandom;
    @(negedge clk_i);
    second_load_i = 1'b0;
    chk(second_operand_o, second_data_i);
    // external RAM paging, aliasing and flash writes
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      pg = v[0];
      xmov_ptr_i = {7'($urandom), pg, 8'($urandom)};
      mem(csdm_pkg::OP_DIRECT, 1'b1, 8'hAA, v);
      op_i = csdm_pkg::OP_NONE;
      flash_cfg_i = 1'b0;
      xm(1'b1, v[2], xmov_ptr_i, v);
      xm(1'b0, !v[2], {7'($urandom), pg, xmov_ptr_i[7:0]}, 8'h00);
      flash_cfg_i = 1'b1;
      xm(1'b1, v[3], $urandom, ~v);
      xmov_req_i = 1'b0;
      flash_cfg_i = 1'b0;
      @(negedge clk_i);
    end
    // code space decode at the lock byte and around it
    code_req_i = 1'b1;
    for (int k = 0; k < 6; k++) begin
      code_addr_i = (k < 5) ? 16'h3DFD + 16'(k) : 16'($urandom);
      #1;
      chk({flash_rd_o, code_lock_o, code_reserved_o}, {code_addr_i <= 16'h3DFF,
          code_addr_i == 16'h3DFF, code_addr_i > 16'h3DFF});
      @(negedge clk_i);
    end
    end_of_test();
  end
endmodule
